// File: core/rlm_defines.vh
`ifndef RLM_DEFINES_VH
`define RLM_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RLM_REF_LOSS_THR_OFS   8'h1b
`define RLM_LOCK_LOSS_THR_OFS  8'h1c
`define RLM_MASK_CTRL_OFS      8'h1d

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RLM_REF_LOSS_THR_RST   8'h01
`define RLM_LOCK_LOSS_THR_RST  8'h10
`define RLM_MASK_CTRL_RST      8'h00

// ----------------------------------------
// Writable bits per register
// ----------------------------------------
`define RLM_REF_LOSS_THR_WMASK 8'h77
`define RLM_LOCK_LOSS_THR_WMASK 8'h1f
`define RLM_MASK_CTRL_WMASK    8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RLM_MISS_EXTRA_MSB     6
`define RLM_MISS_EXTRA_LSB     4
`define RLM_REF_WAIT_MSB       2
`define RLM_REF_WAIT_LSB       0
`define RLM_LOCK_WAIT_MSB      4
`define RLM_LOCK_WAIT_LSB      0
`define RLM_LOCK_HIDE_LSB      4
`define RLM_ALIGN_HIDE_LSB     0

// ----------------------------------------
// Timing
// ----------------------------------------
`define RLM_CLK_PERIOD_NS      40
`define RLM_HSYNC_PERIOD_NS    64000
`define RLM_HSYNC_PERIOD_CLKS  (`RLM_HSYNC_PERIOD_NS / `RLM_CLK_PERIOD_NS)

`endif

// File: core/rlm_regbank.v
`timescale 1ns/1ps
`include "rlm_defines.vh"

module rlm_regbank
(
	input  wire       clock,     // System clock
	input  wire       rst_n,     // Synchronised reset
	input  wire [7:0] addr,      // Register offset
	input  wire [7:0] wdata,     // Write data
	input  wire       write,     // Write strobe
	input  wire       read,      // Read strobe
	output reg  [7:0] rdata_q,   // Registered read data
	output reg  [7:0] ref_thr_q, // Reference-loss threshold
	output reg  [7:0] lock_thr_q,// Lock-loss threshold
	output reg  [7:0] mask_q     // Mask control
);

	// ----------------------------------------
	// Storage and read port
	// ----------------------------------------
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_thr_q  <= `RLM_REF_LOSS_THR_RST;
			lock_thr_q <= `RLM_LOCK_LOSS_THR_RST;
			mask_q     <= `RLM_MASK_CTRL_RST;
			rdata_q    <= 8'h00;
		end
		else
		begin
			if (write && addr == `RLM_REF_LOSS_THR_OFS)
				ref_thr_q <= wdata & `RLM_REF_LOSS_THR_WMASK;
			if (write && addr == `RLM_LOCK_LOSS_THR_OFS)
				lock_thr_q <= wdata & `RLM_LOCK_LOSS_THR_WMASK;
			if (write && addr == `RLM_MASK_CTRL_OFS)
				mask_q <= wdata & `RLM_MASK_CTRL_WMASK;
			if (read)
			begin
				case (addr)
					`RLM_REF_LOSS_THR_OFS:  rdata_q <= ref_thr_q;
					`RLM_LOCK_LOSS_THR_OFS: rdata_q <= lock_thr_q;
					`RLM_MASK_CTRL_OFS:     rdata_q <= mask_q;
					default:                rdata_q <= 8'h00;
				endcase
			end
		end
	end

endmodule // rlm_regbank

// File: core/rlm_monitor.v
`timescale 1ns/1ps
`include "rlm_defines.vh"

// Notes on behaviour
// - Bits 6:4 add extra clocks before the missing-Hsync flag; reset zero.
// - Bits 2:0 count Hsync periods before loss of reference; reset one, use six.
// - Five-bit field counts Hsync periods before PLL1 loss of lock; reset 16.
// - Mask bits 7..4 drop PLL4..PLL1 lock from global lock; reset zero.
// - Mask bits 3,2 drop frame pulse 4,3 alignment from global alignment.
// - Mask bits 1,0 drop frame pulse 2,1 alignment from global alignment.

module rlm_monitor
#(
	parameter HSYNC_PERIOD_CLKS = `RLM_HSYNC_PERIOD_CLKS
)
(
	input  wire       clock,           // 25 MHz clock
	input  wire       reset_n,         // Async reset, active low
	input  wire [7:0] reg_addr,        // Register offset from host interface
	input  wire [7:0] reg_wdata,       // Register write data
	input  wire       reg_write,       // Register write strobe
	input  wire       reg_read,        // Register read strobe
	output wire [7:0] reg_rdata,       // Read data, one cycle after strobe
	output reg        reg_rvalid_q,    // Read data valid pulse
	input  wire       hsync,           // Hsync pulse, one cycle
	input  wire [3:0] pll_lock,        // Per-PLL lock, bit 0 is PLL1
	input  wire [3:0] frame_align,     // Per frame pulse alignment, bit 0 is pulse 1
	output reg        hsync_missing_q, // Hsync gap too long
	output reg        reference_lost_q,// Loss of reference
	output reg        lock_lost_q,     // PLL1 loss of lock
	output reg        lock_status_q,   // Global lock
	output reg        align_status_q   // Global alignment
);

	localparam ST_REF_OK   = 2'b01;
	localparam ST_REF_LOST = 2'b10;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	reg rst_meta_q;
	reg rst_n_q;

	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	wire [7:0] ref_thr;
	wire [7:0] lock_thr;
	wire [7:0] mask;

	rlm_regbank u_regs
	(
		.clock      (clock),
		.rst_n      (rst_n_q),
		.addr       (reg_addr),
		.wdata      (reg_wdata),
		.write      (reg_write),
		.read       (reg_read),
		.rdata_q    (reg_rdata),
		.ref_thr_q  (ref_thr),
		.lock_thr_q (lock_thr),
		.mask_q     (mask)
	);

	wire [2:0] miss_extra = ref_thr[`RLM_MISS_EXTRA_MSB:`RLM_MISS_EXTRA_LSB];
	wire [2:0] ref_wait   = ref_thr[`RLM_REF_WAIT_MSB:`RLM_REF_WAIT_LSB];
	wire [4:0] lock_wait  = lock_thr[`RLM_LOCK_WAIT_MSB:`RLM_LOCK_WAIT_LSB];

	// ----------------------------------------
	// Hsync period timing
	// ----------------------------------------
	reg  [15:0] period_cnt_q;
	reg  [15:0] gap_cnt_q;
	reg  [2:0]  miss_cnt_q;
	reg  [4:0]  lock_cnt_q;
	reg  [1:0]  ref_state_q;
	wire        period_end = (period_cnt_q == HSYNC_PERIOD_CLKS[15:0] - 16'h0001);
	wire        miss_tick  = period_end && !hsync;
	wire        hs_tick    = hsync || miss_tick;
	wire [15:0] miss_limit = HSYNC_PERIOD_CLKS[15:0] + {13'h0000, miss_extra};
	wire [2:0]  ref_limit  = (ref_wait == 3'h0) ? 3'h1 : ref_wait;

	// Read data valid follows the strobe by one clock
	always @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
			reg_rvalid_q <= 1'b0;
		else
			reg_rvalid_q <= reg_read;
	end

	// Period counter restarts on a line pulse or on expiry
	always @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
			period_cnt_q <= 16'h0000;
		else if (hs_tick)
			period_cnt_q <= 16'h0000;
		else
			period_cnt_q <= period_cnt_q + 16'h0001;
	end

	// ----------------------------------------
	// Missing line pulse
	// ----------------------------------------
	// extra clock wait
	always @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			gap_cnt_q       <= 16'h0000;
			hsync_missing_q <= 1'b0;
		end
		else
		begin
			if (hsync)
				gap_cnt_q <= 16'h0000;
			else if (gap_cnt_q != 16'hffff)
				gap_cnt_q <= gap_cnt_q + 16'h0001;
			hsync_missing_q <= !hsync && (gap_cnt_q >= miss_limit);
		end
	end

	// ----------------------------------------
	// Loss of reference
	// ----------------------------------------
	// missed period count
	always @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
			miss_cnt_q <= 3'h0;
		else if (hsync)
			miss_cnt_q <= 3'h0;
		else if (miss_tick && miss_cnt_q != 3'h7)
			miss_cnt_q <= miss_cnt_q + 3'h1;
	end

	always @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ref_state_q      <= ST_REF_OK;
			reference_lost_q <= 1'b0;
		end
		else
		begin
			case (ref_state_q)
				ST_REF_OK:
				begin
					if (!hsync && miss_cnt_q >= ref_limit)
						ref_state_q <= ST_REF_LOST;
				end
				ST_REF_LOST:
				begin
					if (hsync)
						ref_state_q <= ST_REF_OK;
				end
				default: ref_state_q <= ST_REF_OK;
			endcase
			reference_lost_q <= (ref_state_q == ST_REF_LOST) && !hsync;
		end
	end

	// ----------------------------------------
	// Loss of lock
	// ----------------------------------------
	// PLL1 unlock period count
	always @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			lock_cnt_q  <= 5'h00;
			lock_lost_q <= 1'b0;
		end
		else
		begin
			if (pll_lock[0])
				lock_cnt_q <= 5'h00;
			else if (hs_tick && lock_cnt_q != 5'h1f)
				lock_cnt_q <= lock_cnt_q + 5'h01;
			lock_lost_q <= !pll_lock[0] && (lock_cnt_q >= lock_wait);
		end
	end

	// ----------------------------------------
	// Per-channel masking
	// ----------------------------------------
	wire [3:0] lock_ok;
	wire [3:0] align_ok;

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1)
		begin : g_chan
			assign lock_ok[i]  = pll_lock[i] | mask[`RLM_LOCK_HIDE_LSB + i];
			assign align_ok[i] = frame_align[i] | mask[`RLM_ALIGN_HIDE_LSB + i];
		end
	endgenerate

	// ----------------------------------------
	// Global flags
	// ----------------------------------------
	// masked combination
	always @(posedge clock or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			lock_status_q  <= 1'b0;
			align_status_q <= 1'b0;
		end
		else
		begin
			lock_status_q  <= &lock_ok;
			align_status_q <= &align_ok;
		end
	end

endmodule // rlm_monitor

// File: verif/rlm_monitor_sva.sv
`timescale 1ns/1ps
module rlm_monitor_sva
#(
	parameter HSYNC_PERIOD_CLKS = 1600
)
(
	input wire       clock,            // Clock
	input wire       reset_n,          // Async reset, active low
	input wire [7:0] reg_addr,         // Register offset
	input wire [7:0] reg_wdata,        // Write data
	input wire [7:0] reg_rdata,        // Read data
	input wire       reg_write,        // Write strobe
	input wire       reg_read,         // Read strobe
	input wire       reg_rvalid_q,     // Read valid
	input wire       hsync,            // Line pulse
	input wire [3:0] pll_lock,         // Per-PLL lock
	input wire [3:0] frame_align,      // Per-pulse alignment
	input wire       hsync_missing_q,  // Missing line flag
	input wire       reference_lost_q, // Loss of reference
	input wire       lock_lost_q,      // Loss of lock
	input wire       lock_status_q,    // Global lock
	input wire       align_status_q    // Global alignment
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// Settle time after reset
	// ----------------------------------------
	logic [2:0] up_q;
	wire        ok = up_q > 3'h4;
	always @(posedge clock or negedge reset_n)
		if (!reset_n)
			up_q <= 3'h0;
		else if (up_q != 3'h7)
			up_q <= up_q + 3'h1;
	chk_lock_all: assert property (ok && $past(pll_lock) == 4'hf |-> lock_status_q)
		else $error("global lock low with all locked");
	chk_align_all: assert property (ok && $past(frame_align) == 4'hf |-> align_status_q)
		else $error("global align low with all aligned");
	chk_read_answer: assert property (ok && reg_read |=> reg_rvalid_q)
		else $error("read not answered");
	chk_read_cause: assert property (reg_rvalid_q |-> $past(reg_read))
		else $error("read valid without strobe");
	chk_rsvd_zero: assert property (reg_rvalid_q && $past(reg_addr) == 8'h1b |-> !reg_rdata[7] && !reg_rdata[3])
		else $error("reserved bit reads one");
	chk_ref_clear: assert property (ok && hsync |-> ##2 !reference_lost_q)
		else $error("reference lost after line pulse");
	chk_lock_clear: assert property (ok && $past(pll_lock[0]) |-> !lock_lost_q)
		else $error("lock lost while locked");
	chk_miss_clear: assert property (ok && hsync |-> ##2 !hsync_missing_q)
		else $error("missing flag after line pulse");
	cov_ref: cover property (reference_lost_q);
	cov_miss: cover property (hsync_missing_q);
	cov_lock: cover property (lock_lost_q);
endmodule // rlm_monitor_sva

bind rlm_monitor rlm_monitor_sva #(.HSYNC_PERIOD_CLKS(HSYNC_PERIOD_CLKS)) chk_u
(
	.clock            (clock),
	.reset_n          (reset_n),
	.reg_addr         (reg_addr),
	.reg_wdata        (reg_wdata),
	.reg_rdata        (reg_rdata),
	.reg_write        (reg_write),
	.reg_read         (reg_read),
	.reg_rvalid_q     (reg_rvalid_q),
	.hsync            (hsync),
	.pll_lock         (pll_lock),
	.frame_align      (frame_align),
	.hsync_missing_q  (hsync_missing_q),
	.reference_lost_q (reference_lost_q),
	.lock_lost_q      (lock_lost_q),
	.lock_status_q    (lock_status_q),
	.align_status_q   (align_status_q)
);

// File: verif/rlm_host.sv
`timescale 1ns/1ps
module rlm_host
(
	input  wire        clock,                        // System clock
	input  wire  [7:0] reg_rdata,                    // Read data
	input  wire        reg_rvalid_q,                 // Read valid
	output logic [7:0] reg_addr = 8'h00,             // Offset
	output logic [7:0] reg_wdata = 8'h00,            // Write data
	output logic       reg_write = 0,                // Write strobe
	output logic       reg_read = 0                  // Read strobe
);
	task wr(input logic [7:0] a, dt);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= dt;
		reg_write <= 1;
		@(posedge clock);
		reg_write <= 0;
		reg_wdata <= ~dt;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] dt);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1;
		@(posedge clock);
		reg_read <= 0;
		reg_addr <= ~a;
		#1 dt = reg_rvalid_q ? reg_rdata : 8'hxx;
	endtask
endmodule // rlm_host

// File: verif/ref_loss_lock_monitor_cfg_tb.sv
`timescale 1ns/1ps
module ref_loss_lock_monitor_cfg_tb;
	localparam P = 20;
	logic       clock = 0, reset_n = 0, hsync = 0;
	logic [3:0] pll_lock = 4'hf, frame_align = 4'hf;
	logic [7:0] d, m;
	wire  [7:0] ra, wd, rdat;
	wire        wr, rd, rv, miss, rl, ll, ls, as;
	int         fail_count = 0, samples_checked = 0, cyc = 0;
	int         mdl [0:2] = '{8'h01, 8'h10, 8'h00};
	int         wm [0:2] = '{8'h77, 8'h1f, 8'hff};
	int         rstv [0:2] = '{8'h01, 8'h10, 8'h00};
	logic [7:0] mk = 8'h00;
	logic       exp_ls = 0, exp_as = 0;
	int         up = 0;
	always #20 clock = ~clock;
	rlm_monitor #(.HSYNC_PERIOD_CLKS(P)) dut_u (.clock(clock), .reset_n(reset_n),
		.reg_addr(ra), .reg_wdata(wd), .reg_write(wr), .reg_read(rd), .reg_rdata(rdat),
		.reg_rvalid_q(rv), .hsync(hsync), .pll_lock(pll_lock), .frame_align(frame_align),
		.hsync_missing_q(miss), .reference_lost_q(rl), .lock_lost_q(ll),
		.lock_status_q(ls), .align_status_q(as));
	rlm_host host_u (.clock(clock), .reg_rdata(rdat), .reg_rvalid_q(rv), .reg_addr(ra),
		.reg_wdata(wd), .reg_write(wr), .reg_read(rd));
	task chk(string n, logic [7:0] s, e);
		samples_checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task conclude;
		$display("fail_count %0d samples_checked %0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task tick(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Cycle model of the global flags, mask tracked from the bus
	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			up = 0;
			mk = 8'h00;
		end
		else
		begin
			up++;
			if (up > 4)
			begin
				chk("lock_cyc", ls, exp_ls);
				chk("align_cyc", as, exp_as);
			end
		end
		exp_ls = &(pll_lock | mk[7:4]);
		exp_as = &(frame_align | mk[3:0]);
		if (reset_n && wr && ra == 8'h1d)
			mk = wd;
	end
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			fail_count++;
			conclude;
		end
	end
	initial
	begin
		void'($urandom(58));
		repeat (3) @(posedge clock);
		reset_n <= 1;
		tick(3);
		for (int i = 0; i < 8; i++)
		begin
			d = $urandom;
			if (i > 3)
				host_u.wr(8'h1b + i % 4, d);
			if (i > 3 && i % 4 < 3)
				mdl[i % 4] = d & wm[i % 4];
			host_u.rd(8'h1b + i % 4, d);
			chk("reg", d, i % 4 < 3 ? mdl[i % 4] : 0);
		end
		for (int i = 0; i < 16; i++)
		begin
			m = i < 8 ? 8'h01 << i : $urandom;
			host_u.wr(8'h1d, m);
			pll_lock <= i < 8 ? ~m[7:4] : $urandom;
			frame_align <= i < 8 ? ~m[3:0] : $urandom;
			tick(3);
			chk("lock", ls, &(pll_lock | m[7:4]));
			chk("align", as, &(frame_align | m[3:0]));
		end
		// Usual thresholds
		host_u.wr(8'h1b, 8'h76);
		host_u.wr(8'h1c, 8'h07);
		pll_lock <= 4'hf;
		@(posedge clock) hsync <= 1;
		@(posedge clock) hsync <= 0;
		pll_lock <= 4'he;
		tick(P + 7);
		chk("miss", miss, 0);
		tick(1);
		chk("miss", miss, 1);
		tick(93);
		chk("ref", rl, 0);
		tick(1);
		chk("ref", rl, 1);
		chk("lockl", ll, 0);
		tick(18);
		chk("lockl", ll, 0);
		tick(1);
		chk("lockl", ll, 1);
		@(posedge clock) hsync <= 1;
		@(posedge clock) hsync <= 0;
		tick(2);
		chk("ref", rl, 0);
		chk("miss", miss, 0);
		// Reset in mid-run restores the reset values
		@(posedge clock) reset_n <= 0;
		repeat (2) @(posedge clock);
		reset_n <= 1;
		tick(3);
		chk("miss", miss, 0);
		for (int i = 0; i < 3; i++)
		begin
			host_u.rd(8'h1b + i, d);
			chk("rst", d, rstv[i]);
		end
		conclude;
	end
endmodule // ref_loss_lock_monitor_cfg_tb
